// ==== hdl/pscr_pkg.sv ====
// register map, field positions and reset values of the sublayer status/control bank
// assumes a 32-bit apb bus with word-aligned registers
package pscr_pkg;
  // printed offsets are not word multiples: they are register indices, byte address = 4*index
  localparam logic [15:0] PSCR_IDX_MA_STATUS = 16'h18f7;
  localparam logic [15:0] PSCR_IDX_TEST_CTRL = 16'h18f8;
  localparam logic [15:0] PSCR_IDX_CS_CTRL = 16'h3000;
  localparam logic [15:0] PSCR_IDX_CS_CTRL_ALT = 16'h38e6;
  localparam logic [15:0] PSCR_IDX_CS_STATUS = 16'h38e7;
  localparam int PSCR_IDX_W = 16;
  localparam int PSCR_ADDR_LSB = 2;
  localparam int PSCR_ADDR_W = PSCR_IDX_W + PSCR_ADDR_LSB;

  localparam logic [15:0] PSCR_MA_STATUS_RST = 16'h3000;
  localparam logic [15:0] PSCR_CTRL_RST = 16'h0000;

  // medium attachment status fields
  localparam int PSCR_MA_LOOP_ABIL = 13;
  localparam int PSCR_MA_TXLVL_ABIL = 12;
  localparam int PSCR_MA_LOWPWR_ABIL = 11;
  localparam int PSCR_MA_EEE_ABIL = 10;
  localparam int PSCR_MA_RXFLT_ABIL = 9;
  localparam int PSCR_MA_RX_POL = 2;
  localparam int PSCR_MA_RX_FAULT = 1;
  localparam int PSCR_MA_LINK = 0;

  // test field
  localparam int PSCR_TEST_LSB = 13;
  localparam int PSCR_TEST_W = 3;
  localparam logic [2:0] PSCR_TEST_MAX = 3'h3;

  // coding sublayer control / status fields
  localparam int PSCR_CS_SOFT_RESET = 15;
  localparam int PSCR_CS_LOOP = 14;
  localparam int PSCR_CS_TX_LPI_SEEN = 11;
  localparam int PSCR_CS_RX_LPI_SEEN = 10;
  localparam int PSCR_CS_TX_LPI_NOW = 9;
  localparam int PSCR_CS_RX_LPI_NOW = 8;
  localparam int PSCR_CS_FAULT = 7;
  localparam int PSCR_CS_LINK = 2;

  typedef enum logic [2:0] {
    PSCR_TM_NORMAL,
    PSCR_TM_ONE,
    PSCR_TM_TWO,
    PSCR_TM_THREE
  } pscr_test_mode_t;
endpackage

// ==== hdl/pscr_sync.sv ====
// two-flop synchroniser bank for status levels arriving from other logic/pins
// assumes a single clock; clock enable freezes both stages
`timescale 1ns/10ps
module pscr_sync #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  initial begin
    if (WIDTH < 1) $error("pscr_sync: WIDTH must be positive");
  end

  always_comb begin
    meta_d = clk_en ? async_in : meta_q;
    sync_d = clk_en ? meta_q : sync_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// ==== hdl/pscr_latch.sv ====
// sticky event flag bank: hardware set wins over a software write-zero clear
// assumes set and clear are single-clock, already synchronised
`timescale 1ns/10ps
module pscr_latch #(
  parameter int WIDTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] set_in,
  input wire logic [WIDTH-1:0] clr_in,
  input wire logic [WIDTH-1:0] flush_in,
  output logic [WIDTH-1:0] flag_out
);
  logic [WIDTH-1:0] flag_q;
  logic [WIDTH-1:0] flag_d;

  initial begin
    if (WIDTH < 1) $error("pscr_latch: WIDTH must be positive");
  end

  always_comb begin
    flag_d = flag_q;
    if (clk_en) begin
      // a set in the clearing cycle is kept so no event is lost
      flag_d = set_in | (flag_q & ~clr_in & ~flush_in);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_out = flag_q;
endmodule

// ==== hdl/pscr_regs.sv ====
// apb register bank: medium-attachment and coding-sublayer status and control
// assumes status levels come from the line logic unsynchronised; single clock pclk
//
// Overview of operation
// - medium status bit 13 reads constant one: loopback supported
// - medium status bit 12 reads constant one: 2.4 Vpp level supported
// - medium status bit 11 reads constant zero: no low-power capability
// - medium status bit 10 reads constant zero: no energy-efficient mode
// - medium status bit 9 reads constant zero: no receive fault detection
// - medium status bit 2 shows inverted receive polarity, read-only
// - medium status bit 1 latches receive fault; write zero clears it
// - medium status bit 0 shows receive link, write-zero-to-set access
// - test field bits 15:13 select normal or test modes 1-3; 1xx reserved
// - coding control bit 15 resets coding sublayer then clears itself
// - coding control bit 14 enables coding-sublayer loopback
// - coding status bit 11 latches transmit low-power idle; write zero clears
// - coding status bit 10 latches receive low-power idle; write zero clears
// - coding status bit 9 shows transmit currently in low-power idle
// - coding status bit 8 shows receive currently in low-power idle
// - coding status bit 7 latches fault; write zero clears
// - coding status bit 2 shows coding-sublayer receive link
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
module pscr_regs
  import pscr_pkg::*;
#(
  parameter int SOFT_RESET_CYCLES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PSCR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_polarity_inverted,
  input wire logic rx_fault_event,
  input wire logic ma_link_up,
  input wire logic tx_lpi_active,
  input wire logic rx_lpi_active,
  input wire logic cs_fault_event,
  input wire logic cs_link_up,
  output logic [PSCR_TEST_W-1:0] test_mode,
  output logic coding_sublayer_soft_reset,
  output logic coding_sublayer_loop_enable
);
  localparam int NSYNC = 7;
  localparam int NFLAG = 4;
  localparam int CNT_W = $clog2(SOFT_RESET_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(SOFT_RESET_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  initial begin
    if (SOFT_RESET_CYCLES < 1) $error("pscr_regs: SOFT_RESET_CYCLES must be at least 1");
  end

  // synchronised status levels
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn;
  logic s_pol, s_rxflt, s_malink, s_txlpi, s_rxlpi, s_csflt, s_cslink;

  assign raw_in = {cs_link_up, cs_fault_event, rx_lpi_active, tx_lpi_active,
                   ma_link_up, rx_fault_event, rx_polarity_inverted};
  assign {s_cslink, s_csflt, s_rxlpi, s_txlpi, s_malink, s_rxflt, s_pol} = syn;

  pscr_sync #(.WIDTH(NSYNC)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .async_in(raw_in),
    .sync_out(syn)
  );

  // apb decode: registers answer with zero wait states
  logic acc, wr, rd;
  logic [PSCR_IDX_W-1:0] idx;
  logic hit_ma, hit_test, hit_cs, hit_cs_alt, hit_cs_st, hit_any;
  logic lo_wr; // byte lanes 0 and 1 carry the 16-bit register

  assign acc = psel & penable & clk_en;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign idx = paddr[PSCR_ADDR_W-1:PSCR_ADDR_LSB];
  assign lo_wr = pstrb[0] & pstrb[1];

  always_comb begin
    hit_ma = 1'b0;
    hit_test = 1'b0;
    hit_cs = 1'b0;
    hit_cs_alt = 1'b0;
    hit_cs_st = 1'b0;
    if (idx == PSCR_IDX_MA_STATUS) begin
      hit_ma = 1'b1;
    end else if (idx == PSCR_IDX_TEST_CTRL) begin
      hit_test = 1'b1;
    end else if (idx == PSCR_IDX_CS_CTRL) begin
      hit_cs = 1'b1;
    end else if (idx == PSCR_IDX_CS_CTRL_ALT) begin
      hit_cs_alt = 1'b1;
    end else if (idx == PSCR_IDX_CS_STATUS) begin
      hit_cs_st = 1'b1;
    end
  end
  assign hit_any = hit_ma | hit_test | hit_cs | hit_cs_alt | hit_cs_st;

  // control state
  logic [PSCR_TEST_W-1:0] test_q, test_d;
  logic loop_q, loop_d;
  logic srst_q, srst_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic link_wr_q, link_wr_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;

  // latched flags: 0 rx fault, 1 tx lpi seen, 2 rx lpi seen, 3 cs fault
  logic [NFLAG-1:0] flag_set, flag_clr, flag_flush, flags;
  logic ma_wr0, cs_wr0;

  assign ma_wr0 = wr & hit_ma & lo_wr;
  assign cs_wr0 = wr & hit_cs_st & lo_wr;
  assign flag_set = {s_csflt, s_rxlpi, s_txlpi, s_rxflt};
  assign flag_clr = {cs_wr0 & ~pwdata[PSCR_CS_FAULT],
                     cs_wr0 & ~pwdata[PSCR_CS_RX_LPI_SEEN],
                     cs_wr0 & ~pwdata[PSCR_CS_TX_LPI_SEEN],
                     ma_wr0 & ~pwdata[PSCR_MA_RX_FAULT]};
  // a sublayer reset also flushes the coding-sublayer latches
  assign flag_flush = {srst_q, srst_q, srst_q, 1'b0};

  pscr_latch #(.WIDTH(NFLAG)) u_latch (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .set_in(flag_set),
    .clr_in(flag_clr),
    .flush_in(flag_flush),
    .flag_out(flags)
  );

  // read views; reserved positions stay zero
  logic [15:0] ma_view, test_view, cs_view, cs_st_view;

  always_comb begin
    ma_view = '0;
    ma_view[PSCR_MA_LOOP_ABIL] = 1'b1;
    ma_view[PSCR_MA_TXLVL_ABIL] = 1'b1;
    ma_view[PSCR_MA_LOWPWR_ABIL] = 1'b0;
    ma_view[PSCR_MA_EEE_ABIL] = 1'b0;
    ma_view[PSCR_MA_RXFLT_ABIL] = 1'b0;
    ma_view[PSCR_MA_RX_POL] = s_pol;
    ma_view[PSCR_MA_RX_FAULT] = flags[0];
    // a write of zero forces the link bit up until the link logic next drops
    ma_view[PSCR_MA_LINK] = s_malink | link_wr_q;
    test_view = '0;
    test_view[PSCR_TEST_LSB +: PSCR_TEST_W] = test_q;
    cs_view = '0;
    cs_view[PSCR_CS_SOFT_RESET] = srst_q;
    cs_view[PSCR_CS_LOOP] = loop_q;
    cs_st_view = '0;
    cs_st_view[PSCR_CS_TX_LPI_SEEN] = flags[1];
    cs_st_view[PSCR_CS_RX_LPI_SEEN] = flags[2];
    cs_st_view[PSCR_CS_TX_LPI_NOW] = s_txlpi;
    cs_st_view[PSCR_CS_RX_LPI_NOW] = s_rxlpi;
    cs_st_view[PSCR_CS_FAULT] = flags[3];
    cs_st_view[PSCR_CS_LINK] = s_cslink;
  end

  always_comb begin
    test_d = test_q;
    loop_d = loop_q;
    srst_d = srst_q;
    cnt_d = cnt_q;
    link_wr_d = link_wr_q;
    prdata_d = prdata_q;
    // a low clock enable freezes the answer flops along with the rest of the state
    pready_d = pready_q;
    pslverr_d = pslverr_q;
    if (clk_en) begin
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      // self-clearing sublayer reset pulse of fixed length
      if (srst_q) begin
        if (cnt_q == CNT_ONE) begin
          srst_d = 1'b0;
        end
        cnt_d = cnt_q - CNT_ONE;
      end
      if (!s_malink) begin
        link_wr_d = 1'b0;
      end
      if (psel && !penable) begin
        pready_d = 1'b1;
        pslverr_d = ~hit_any;
        prdata_d = '0;
        if (!pwrite) begin
          if (hit_ma) begin
            prdata_d = {16'h0000, ma_view};
          end else if (hit_test) begin
            prdata_d = {16'h0000, test_view};
          end else if (hit_cs || hit_cs_alt) begin
            prdata_d = {16'h0000, cs_view};
          end else if (hit_cs_st) begin
            prdata_d = {16'h0000, cs_st_view};
          end
        end
      end
      if (wr && lo_wr) begin
        if (hit_ma && !pwdata[PSCR_MA_LINK]) begin
          link_wr_d = 1'b1;
        end else if (hit_test) begin
          // reserved codes are refused so the selector always names a real mode
          if (pwdata[PSCR_TEST_LSB +: PSCR_TEST_W] <= PSCR_TEST_MAX) begin
            test_d = pwdata[PSCR_TEST_LSB +: PSCR_TEST_W];
          end
        end else if (hit_cs || hit_cs_alt) begin
          loop_d = pwdata[PSCR_CS_LOOP];
          if (pwdata[PSCR_CS_SOFT_RESET]) begin
            srst_d = 1'b1;
            cnt_d = CNT_LOAD;
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_q <= PSCR_CTRL_RST[PSCR_TEST_LSB +: PSCR_TEST_W];
      loop_q <= PSCR_CTRL_RST[PSCR_CS_LOOP];
      srst_q <= PSCR_CTRL_RST[PSCR_CS_SOFT_RESET];
      cnt_q <= '0;
      link_wr_q <= PSCR_MA_STATUS_RST[PSCR_MA_LINK];
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      test_q <= test_d;
      loop_q <= loop_d;
      srst_q <= srst_d;
      cnt_q <= cnt_d;
      link_wr_q <= link_wr_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign test_mode = test_q;
  assign coding_sublayer_soft_reset = srst_q;
  assign coding_sublayer_loop_enable = loop_q;
endmodule

// ==== testbench/pscr_regs_props.sv ====
// assertion checker for the apb status/control bank
// assumes one pclk domain; bound to every pscr_regs instance
`timescale 1ns/10ps
module pscr_regs_props
  import pscr_pkg::*;
#(
  parameter int SOFT_RESET_CYCLES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PSCR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [PSCR_TEST_W-1:0] test_mode,
  input wire logic coding_sublayer_soft_reset,
  input wire logic coding_sublayer_loop_enable
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [15:0] idx;
  logic wr_ok;
  logic mapped;
  int hi_q;
  int hi_d;
  assign idx = paddr[PSCR_ADDR_W-1:PSCR_ADDR_LSB];
  assign wr_ok = psel && penable && pwrite && pready && clk_en && pstrb[1:0] == 2'b11;
  assign mapped = idx inside {PSCR_IDX_MA_STATUS, PSCR_IDX_TEST_CTRL, PSCR_IDX_CS_CTRL,
    PSCR_IDX_CS_CTRL_ALT, PSCR_IDX_CS_STATUS};
  // length of the sublayer reset pulse, frozen while the clock enable is low
  always_comb hi_d = !clk_en ? hi_q : (coding_sublayer_soft_reset ? hi_q + 1 : 0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hi_q <= 0;
    else hi_q <= hi_d;
  end
  sequence setup_s;
    psel && !penable && clk_en;
  endsequence
  sequence cs_ctrl_wr_s;
    wr_ok && (idx == PSCR_IDX_CS_CTRL || idx == PSCR_IDX_CS_CTRL_ALT);
  endsequence
  ready_next_a:
    assert property (setup_s |=> pready) else $error("no answer after setup");
  ready_pulse_a:
    assert property (pready && clk_en |=> !pready) else $error("answer held too long");
  unmapped_err_a:
    assert property (pready |-> pslverr == !mapped) else $error("error flag wrong");
  fixed_bits_a:
    assert property (pready && !pwrite && idx == PSCR_IDX_MA_STATUS |-> prdata[15:3] == 13'h0600)
      else $error("fixed status bits wrong");
  upper_zero_a:
    assert property (pready |-> prdata[31:16] == 16'h0000) else $error("upper half not zero");
  test_range_a:
    assert property (test_mode <= PSCR_TEST_MAX) else $error("reserved test code taken");
  test_write_a:
    assert property (wr_ok && idx == PSCR_IDX_TEST_CTRL && !pwdata[15]
      |=> test_mode == $past(pwdata[15:13])) else $error("test code not taken");
  loop_write_a:
    assert property (cs_ctrl_wr_s |=> coding_sublayer_loop_enable == $past(pwdata[14]))
      else $error("loop enable not taken");
  soft_start_a:
    assert property (cs_ctrl_wr_s ##0 pwdata[15] |-> ##[1:2] coding_sublayer_soft_reset)
      else $error("sublayer reset not started");
  soft_length_a:
    assert property ($fell(coding_sublayer_soft_reset) |-> hi_q == SOFT_RESET_CYCLES)
      else $error("sublayer reset length wrong");
  soft_bound_a:
    assert property (coding_sublayer_soft_reset |-> hi_q < SOFT_RESET_CYCLES)
      else $error("sublayer reset too long");
endmodule

bind pscr_regs pscr_regs_props #(.SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)) u_props (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .test_mode(test_mode),
  .coding_sublayer_soft_reset(coding_sublayer_soft_reset),
  .coding_sublayer_loop_enable(coding_sublayer_loop_enable)
);

// ==== testbench/tb_pscr_regs.sv ====
// self-checking bench for pscr_regs: apb master, status stimulus, bench-side model
// assumes the bank answers every access; clock enable drops only in one idle freeze window
`timescale 1ns/10ps
module tb_pscr_regs
  import pscr_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [PSCR_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [6:0] lv = 7'h0;
  logic ce = 1'b1;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] test_mode;
  logic sr;
  logic loop;
  logic [31:0] rd;
  logic [31:0] d;
  logic [3:0] s;
  logic err;
  logic [2:0] m_test = 3'h0;
  logic m_loop = 1'b0;
  // ma fault, tx idle seen, rx idle seen, cs fault
  logic [3:0] m_lat = 4'h0;
  int failures = 0;
  int total_checks = 0;
  int seed = 41;
  logic [15:0] map [5] = '{PSCR_IDX_MA_STATUS, PSCR_IDX_TEST_CTRL, PSCR_IDX_CS_CTRL,
    PSCR_IDX_CS_CTRL_ALT, PSCR_IDX_CS_STATUS};

  always #10 pclk = ~pclk;

  pscr_regs #(.SOFT_RESET_CYCLES(4)) uut (
    .pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_polarity_inverted(lv[6]), .rx_fault_event(lv[5]),
    .ma_link_up(lv[4]), .tx_lpi_active(lv[3]), .rx_lpi_active(lv[2]),
    .cs_fault_event(lv[1]), .cs_link_up(lv[0]), .test_mode(test_mode),
    .coding_sublayer_soft_reset(sr), .coding_sublayer_loop_enable(loop)
  );

  function automatic logic [31:0] model(input logic [15:0] i);
    case (i)
      PSCR_IDX_MA_STATUS: return {18'h0, 5'h18, 6'h0, lv[6], m_lat[3], lv[4]};
      PSCR_IDX_TEST_CTRL: return {16'h0, m_test, 13'h0};
      PSCR_IDX_CS_CTRL, PSCR_IDX_CS_CTRL_ALT: return {17'h0, m_loop, 14'h0};
      PSCR_IDX_CS_STATUS: return {20'h0, m_lat[2:1], lv[3], lv[2], m_lat[0], 4'h0, lv[0], 2'h0};
      default: return 32'h0;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [15:0] i, input logic [31:0] wd,
    input logic [3:0] ws);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {i, 2'b00};
    pwdata <= wd;
    pstrb <= ws;
    @(posedge pclk);
    penable <= 1'b1;
    // ready, read data and error are all taken at the rising edge that ends the access
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, pready === 1'b1}, 32'h1);
    if (wr && ws[1:0] == 2'b11) begin
      case (i)
        PSCR_IDX_MA_STATUS: m_lat[3] = m_lat[3] & wd[1];
        PSCR_IDX_TEST_CTRL: m_test = wd[15] ? m_test : wd[15:13];
        PSCR_IDX_CS_CTRL, PSCR_IDX_CS_CTRL_ALT: begin
          m_loop = wd[14];
          m_lat[2:0] = wd[15] ? 3'h0 : m_lat[2:0];
        end
        PSCR_IDX_CS_STATUS: m_lat[2:0] = m_lat[2:0] & {wd[11], wd[10], wd[7]};
        default: ;
      endcase
    end
  endtask

  task automatic rd_cmp(input logic [15:0] i);
    logic hit;
    hit = 1'b0;
    foreach (map[k]) hit |= (map[k] == i);
    apb(1'b0, i, $random(seed), 4'h0);
    chk(rd, model(i));
    chk({31'h0, err}, {31'h0, !hit});
  endtask

  task automatic port_cmp();
    // the write lands at the edge the bus task returns on; look once it has settled
    @(negedge pclk);
    chk({29'h0, test_mode}, {29'h0, m_test});
    chk({31'h0, loop}, {31'h0, m_loop});
  endtask

  task automatic wrap_up();
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (map[k]) rd_cmp(map[k]);
    rd_cmp(16'h18f9);
    for (int c = 0; c < 8; c++) begin
      d = $random(seed);
      d[15:13] = c[2:0];
      apb(1'b1, PSCR_IDX_TEST_CTRL, d, 4'hf);
      port_cmp();
      rd_cmp(PSCR_IDX_TEST_CTRL);
    end
    // partial strobes must leave the field alone
    s = $random(seed);
    s[1] = 1'b0;
    apb(1'b1, PSCR_IDX_TEST_CTRL, 32'h2000, s);
    rd_cmp(PSCR_IDX_TEST_CTRL);
    apb(1'b1, PSCR_IDX_CS_CTRL, 32'h4000, 4'hf);
    port_cmp();
    rd_cmp(PSCR_IDX_CS_CTRL_ALT);
    apb(1'b1, PSCR_IDX_CS_CTRL_ALT, 32'h0, 4'hf);
    port_cmp();
    rd_cmp(PSCR_IDX_CS_CTRL);
    repeat (8) begin
      @(posedge pclk);
      lv <= $random(seed);
      repeat (5) @(posedge pclk);
      m_lat = m_lat | {lv[5], lv[3], lv[2], lv[1]};
      rd_cmp(PSCR_IDX_MA_STATUS);
      rd_cmp(PSCR_IDX_CS_STATUS);
      lv <= 7'h0;
      repeat (5) @(posedge pclk);
      rd_cmp(PSCR_IDX_MA_STATUS);
      rd_cmp(PSCR_IDX_CS_STATUS);
      d = $random(seed);
      // random bit 0 also writes zero to the link bit while the link is down
      apb(1'b1, PSCR_IDX_MA_STATUS, d, 4'hf);
      apb(1'b1, PSCR_IDX_CS_STATUS, $random(seed), 4'hf);
      rd_cmp(PSCR_IDX_MA_STATUS);
      rd_cmp(PSCR_IDX_CS_STATUS);
    end
    lv <= 7'h0e;
    repeat (5) @(posedge pclk);
    m_lat[2:0] = 3'h7;
    lv <= 7'h0;
    repeat (5) @(posedge pclk);
    apb(1'b1, PSCR_IDX_CS_CTRL, 32'hc000, 4'hf);
    repeat (2) @(negedge pclk);
    chk({31'h0, sr}, 32'h1);
    repeat (8) @(posedge pclk);
    chk({31'h0, sr}, 32'h0);
    port_cmp();
    rd_cmp(PSCR_IDX_CS_CTRL);
    rd_cmp(PSCR_IDX_CS_STATUS);
    // fault pulses that live only while the clock enable is low must never be seen
    ce <= 1'b0;
    lv <= 7'h22;
    repeat (4) @(posedge pclk);
    lv <= 7'h0;
    @(posedge pclk);
    ce <= 1'b1;
    repeat (5) @(posedge pclk);
    rd_cmp(PSCR_IDX_MA_STATUS);
    rd_cmp(PSCR_IDX_CS_STATUS);
    wrap_up();
  end
endmodule
